// ===== include/adc_xclk_pkg.sv
// Constants, encodings and types shared by the serial conversion port.
// What this block does
// - Clock mode 11: conversion byte write starts one conversion timed by serial clock.
// - Clock mode 11 ignores configured scanning and averaging; one channel, once.
// - Clock mode 11 shifts the result out while the conversion runs.
// - Temperature result appears on data out during the last 2 bytes.
// - First byte of entry cut short: next read gives the entry's low byte, bits 7..0.
// - First byte read, second cut short: rest of entry is dropped.
// - Later entries survive partial reads; host ignores 4 leading zero bits.
// - Truncated write updates bits from MSB down; lower bits keep old value.
// - Chip select low before end-of-conversion aborts conversion and clears FIFO, outside clock mode 11.
// - Results are straight binary; voltage word and temperature word packing.
// - End-of-conversion stays low until chip select or convert-start falls.
package adc_xclk_pkg;

	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int CS_HIGH_MAX_US = 100;
	localparam int CS_HIGH_MAX_CYCLES = CS_HIGH_MAX_US * 1000 / CLK_PERIOD_NS;

	// Serial framing counts
	localparam int BYTE_BITS = 8;
	localparam int XCONV_CLOCKS = 16;
	localparam int TEMP_CLOCKS = 192;
	localparam int RESULT_BITS = 16;
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] BYTE_LAST = 4'(BYTE_BITS - 1);
	localparam logic [3:0] FULL_BYTE = 4'(BYTE_BITS);
	localparam logic [7:0] XCONV_LAST = 8'(XCONV_CLOCKS - 1);
	localparam logic [7:0] TEMP_LAST = 8'(TEMP_CLOCKS - 1);
	localparam logic [7:0] TEMP_OUT_FIRST = 8'(TEMP_CLOCKS - RESULT_BITS);
	localparam logic [4:0] RD_SECOND_BYTE = 5'(BYTE_BITS);
	localparam logic [4:0] RD_LAST = 5'(RESULT_BITS - 1);

	// Clock-mode codes
	localparam logic [1:0] CLK_MODE_00 = 2'h0;
	localparam logic [1:0] CLK_MODE_01 = 2'h1;
	localparam logic [1:0] CLK_MODE_EXT = 2'h3;

	// Conversion register fields
	localparam int CONV_CHAN_LSB = 3;
	localparam int CONV_SCAN_LSB = 1;
	localparam int CONV_TEMP_BIT = 0;
	// Setup register fields
	localparam int SETUP_CLK_LSB = 4;
	localparam int SETUP_REF_LSB = 2;
	// Averaging register fields
	localparam int AVG_ON_BIT = 4;
	localparam int AVG_N_LSB = 2;
	// Reset register: 0 resets all registers, 1 clears the FIFO only
	localparam int RST_FIFO_ONLY_BIT = 3;

	// Values after reset (prefix bits included; clock mode 10)
	localparam logic [7:0] CONV_RST = 8'h80;
	localparam logic [7:0] SETUP_RST = 8'h60;
	localparam logic [7:0] AVG_RST = 8'h20;

	typedef enum {SEL_NONE, SEL_CONV, SEL_SETUP, SEL_AVG, SEL_RESET} reg_sel_t;
	typedef enum {PH_IDLE, PH_XCONV, PH_TEMP} phase_t;

endpackage

// ===== verilog/result_fifo.sv
// Result FIFO with valid/ready on both sides and a synchronous clear.
`timescale 1ns/1ps
module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [CW-1:0] count;
		logic in_rdy;
	} fifo_state_t;

	fifo_state_t s;
	fifo_state_t next_s;
	logic push;
	logic pop;

	// Pointer and count update; ready is registered so it never glitches
	always_comb begin
		next_s = s;
		push = in_valid_i & s.in_rdy;
		pop = out_ready_i & (s.count != '0);
		if (push) begin
			next_s.mem[s.wr_ptr] = in_data_i;
			next_s.wr_ptr = s.wr_ptr + AW'(1);
		end
		if (pop) begin
			next_s.rd_ptr = s.rd_ptr + AW'(1);
		end
		next_s.count = s.count + CW'(push) - CW'(pop);
		if (clear_i) begin
			next_s.wr_ptr = '0;
			next_s.rd_ptr = '0;
			next_s.count = '0;
		end
		next_s.in_rdy = (next_s.count != CW'(DEPTH));
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s <= '0;
			s.in_rdy <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign in_ready_o = s.in_rdy;
	assign out_valid_o = (s.count != '0);
	assign out_data_o = s.mem[s.rd_ptr];
endmodule

// ===== verilog/adc_serial_port.sv
// Serial port control of the ADC: register writes, externally clocked conversion, FIFO readout.
`timescale 1ns/1ps
module adc_serial_port
	import adc_xclk_pkg::*;
#(
	parameter int unsigned CS_HIGH_LIMIT = CS_HIGH_MAX_CYCLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Serial pins, asynchronous to mclk_i
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic din_i,
	output logic dout_o,
	output logic dout_oe_o,
	// Conversion control pins
	input wire logic convert_start_n_i,
	output logic eoc_n_o,
	// Analog core request and result, same clock
	output logic conv_start_o,
	output logic [3:0] conv_chan_o,
	output logic conv_temp_o,
	input wire logic conv_done_i,
	input wire logic [11:0] conv_data_i,
	// Internal sequencer for the other clock modes
	output logic int_start_o,
	output logic abort_o,
	input wire logic scan_done_i,
	output logic [1:0] clk_mode_o,
	output logic [1:0] ref_mode_o,
	output logic [1:0] scan_mode_o,
	output logic avg_on_o,
	output logic [1:0] avg_count_o,
	// Result words from the internal sequencer into the FIFO
	input wire logic res_valid_i,
	input wire logic [RESULT_BITS-1:0] res_data_i,
	output logic res_ready_o
);

	typedef struct packed {
		logic [2:0] sclk_s;
		logic [2:0] cs_s;
		logic [2:0] cst_s;
		logic [1:0] din_s;
		logic [7:0] rx_sr;
		logic [3:0] rx_cnt;
		logic [7:0] conv_reg;
		logic [7:0] setup_reg;
		logic [7:0] avg_reg;
		phase_t phase;
		logic [7:0] xcnt;
		logic [RESULT_BITS-1:0] xword;
		logic [4:0] rd_bit;
		logic [15:0] hi_cnt;
		logic busy;
		logic dout;
		logic dout_oe;
		logic eoc_n;
		logic conv_start;
		logic int_start;
		logic abort;
		logic flush;
		logic [1:0] scan_mode;
		logic avg_on;
	} port_state_t;

	port_state_t s;
	port_state_t next_s;

	logic pop;
	logic fifo_valid;
	logic [RESULT_BITS-1:0] fifo_head;
	logic fifo_in_ready;

	// Overlay the top n shifted bits onto an old register value
	function automatic logic [7:0] merge_bits(input logic [7:0] old, input logic [7:0] sr,
			input logic [3:0] n);
		logic [7:0] keep;
		keep = 8'hFF >> n;
		merge_bits = (old & keep) | (sr << (FULL_BYTE - n));
	endfunction

	// Which register the leading bits address; needs enough bits to tell
	function automatic reg_sel_t decode_sel(input logic [7:0] sr, input logic [3:0] n);
		logic [7:0] a;
		a = sr << (FULL_BYTE - n);
		if (n >= 4'h1 && a[7])
			decode_sel = SEL_CONV;
		else if (n >= 4'h2 && a[7:6] == 2'h1)
			decode_sel = SEL_SETUP;
		else if (n >= 4'h3 && a[7:5] == 3'h1)
			decode_sel = SEL_AVG;
		else if (n >= 4'h4 && a[7:4] == 4'h1)
			decode_sel = SEL_RESET;
		else
			decode_sel = SEL_NONE;
	endfunction

	result_fifo #(
		.WIDTH(RESULT_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clear_i(s.flush),
		.in_valid_i(res_valid_i),
		.in_data_i(res_data_i),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_head),
		.out_ready_i(pop)
	);

	// Whole port: sync, edge detect, writes, conversion sequencing, readout
	always_comb begin
		logic sclk_rise;
		logic sclk_fall;
		logic cs_fall;
		logic cs_rise;
		logic cs_low;
		logic cst_fall;
		logic ext;
		logic wr_en;
		logic wr_full;
		logic [7:0] wr_sr;
		logic [3:0] wr_n;
		logic [7:0] tidx;
		reg_sel_t sel;
		next_s = s;
		pop = 1'b0;
		wr_en = 1'b0;
		wr_full = 1'b0;
		wr_sr = 8'h00;
		wr_n = 4'h0;
		tidx = 8'h00;
		sel = SEL_NONE;
		// Two flops before any use; edges from stages two and three only
		next_s.sclk_s = {s.sclk_s[1:0], sclk_i};
		next_s.cs_s = {s.cs_s[1:0], cs_n_i};
		next_s.cst_s = {s.cst_s[1:0], convert_start_n_i};
		next_s.din_s = {s.din_s[0], din_i};
		sclk_rise = s.sclk_s[1] & ~s.sclk_s[2];
		sclk_fall = ~s.sclk_s[1] & s.sclk_s[2];
		cs_fall = ~s.cs_s[1] & s.cs_s[2];
		cs_rise = s.cs_s[1] & ~s.cs_s[2];
		cs_low = ~s.cs_s[1];
		cst_fall = ~s.cst_s[1] & s.cst_s[2];
		ext = (s.setup_reg[SETUP_CLK_LSB +: 2] == CLK_MODE_EXT);
		next_s.conv_start = 1'b0;
		next_s.int_start = 1'b0;
		next_s.abort = 1'b0;
		next_s.flush = 1'b0;

		// Scan and averaging reach the sequencer only outside mode 11
		next_s.scan_mode = ext ? 2'h0 : s.conv_reg[CONV_SCAN_LSB +: 2];
		next_s.avg_on = ext ? 1'b0 : s.avg_reg[AVG_ON_BIT];

		// Straight binary packing: 4 zero leads, then the code
		if (conv_done_i && s.phase != PH_IDLE) begin
			if (s.phase == PH_TEMP)
				next_s.xword = {4'h0, conv_data_i};
			else
				next_s.xword = {4'h0, conv_data_i[9:0], 2'h0};
		end

		// A chip-select gap mid voltage conversion is tolerated only briefly
		if (!cs_low && s.phase == PH_XCONV) begin
			next_s.hi_cnt = s.hi_cnt + 16'h0001;
			if (32'(s.hi_cnt) >= CS_HIGH_LIMIT) begin
				next_s.phase = PH_IDLE;
				next_s.abort = 1'b1;
			end
		end

		if (cs_fall) begin
			next_s.hi_cnt = 16'h0000;
			next_s.rx_cnt = 4'h0;
			next_s.eoc_n = 1'b1;
			if (s.busy) begin
				next_s.busy = 1'b0;
				next_s.abort = 1'b1;
				next_s.flush = 1'b1;
			end
		end

		// Truncated byte and truncated FIFO entry at chip-select rise
		if (cs_rise) begin
			if (s.rx_cnt != 4'h0) begin
				wr_en = 1'b1;
				wr_sr = s.rx_sr;
				wr_n = s.rx_cnt;
			end
			if (s.rd_bit != 5'h00 && s.rd_bit < RD_SECOND_BYTE) begin
				next_s.rd_bit = RD_SECOND_BYTE;
			end else if (s.rd_bit > RD_SECOND_BYTE) begin
				pop = 1'b1;
				next_s.rd_bit = 5'h00;
			end
		end

		// Convert-start pin releases the end flag in any mode, starts in clock modes 00 and 01 only; ahead of the end of a conversion
		if (cst_fall) begin
			next_s.eoc_n = 1'b1;
			if (!ext && (s.setup_reg[SETUP_CLK_LSB +: 2] == CLK_MODE_00 ||
					s.setup_reg[SETUP_CLK_LSB +: 2] == CLK_MODE_01)) begin
				next_s.int_start = 1'b1;
				next_s.busy = 1'b1;
			end
		end

		if (sclk_rise && cs_low) begin
			// Conversion clocks come from the serial clock itself
			case (s.phase)
				PH_XCONV: begin
					next_s.xcnt = s.xcnt + 8'h01;
					if (s.xcnt == XCONV_LAST) begin
						next_s.phase = PH_IDLE;
						next_s.eoc_n = 1'b0;
					end
				end
				PH_TEMP: begin
					next_s.xcnt = s.xcnt + 8'h01;
					if (s.xcnt == TEMP_LAST) begin
						next_s.phase = PH_IDLE;
						next_s.eoc_n = 1'b0;
					end
				end
				default: begin
					// FIFO is not the result path in mode 11
					if (!ext && fifo_valid) begin
						next_s.rd_bit = s.rd_bit + 5'h01;
						if (s.rd_bit == RD_LAST) begin
							pop = 1'b1;
							next_s.rd_bit = 5'h00;
						end
					end
				end
			endcase
			// Byte receiver runs under conversions so a new byte can follow a zero byte
			next_s.rx_sr = {s.rx_sr[6:0], s.din_s[1]};
			next_s.rx_cnt = s.rx_cnt + 4'h1;
			if (s.rx_cnt == BYTE_LAST) begin
				next_s.rx_cnt = 4'h0;
				wr_en = 1'b1;
				wr_full = 1'b1;
				wr_sr = {s.rx_sr[6:0], s.din_s[1]};
				wr_n = FULL_BYTE;
			end
		end

		// Register update; only a whole byte triggers actions
		if (wr_en) begin
			sel = decode_sel(wr_sr, wr_n);
			case (sel)
				SEL_CONV: begin
					next_s.conv_reg = merge_bits(s.conv_reg, wr_sr, wr_n);
					if (wr_full && ext) begin
						next_s.phase = wr_sr[CONV_TEMP_BIT] ? PH_TEMP : PH_XCONV;
						next_s.xcnt = 8'h00;
						next_s.xword = '0;
						next_s.hi_cnt = 16'h0000;
						next_s.conv_start = 1'b1;
					end else if (wr_full) begin
						next_s.int_start = 1'b1;
						next_s.busy = 1'b1;
					end
				end
				SEL_SETUP: begin
					next_s.setup_reg = merge_bits(s.setup_reg, wr_sr, wr_n);
				end
				SEL_AVG: begin
					next_s.avg_reg = merge_bits(s.avg_reg, wr_sr, wr_n);
				end
				SEL_RESET: begin
					if (wr_full) begin
						next_s.flush = 1'b1;
						next_s.rd_bit = 5'h00;
						if (!wr_sr[RST_FIFO_ONLY_BIT]) begin
							next_s.conv_reg = CONV_RST;
							next_s.setup_reg = SETUP_RST;
							next_s.avg_reg = AVG_RST;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// Completion wins over a clearing edge in the same cycle
		if (scan_done_i) begin
			next_s.busy = 1'b0;
			next_s.eoc_n = 1'b0;
		end

		// Data out changes on falling serial clock, first bit at chip-select fall
		next_s.dout_oe = cs_low;
		if ((sclk_fall && cs_low) || cs_fall) begin
			case (next_s.phase)
				PH_XCONV: begin
					next_s.dout = next_s.xword[4'hF - next_s.xcnt[3:0]];
				end
				PH_TEMP: begin
					tidx = next_s.xcnt - TEMP_OUT_FIRST;
					if (next_s.xcnt >= TEMP_OUT_FIRST)
						next_s.dout = next_s.xword[4'hF - tidx[3:0]];
					else
						next_s.dout = 1'b0;
				end
				default: begin
					next_s.dout = (!ext && fifo_valid) ? fifo_head[4'hF - next_s.rd_bit[3:0]] : 1'b0;
				end
			endcase
		end
		if (!cs_low)
			next_s.dout = 1'b0;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			s <= '0;
			s.sclk_s <= 3'h0;
			s.cs_s <= 3'h7;
			s.cst_s <= 3'h7;
			s.conv_reg <= CONV_RST;
			s.setup_reg <= SETUP_RST;
			s.avg_reg <= AVG_RST;
			s.phase <= PH_IDLE;
			s.eoc_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from state flops
	assign dout_o = s.dout;
	assign dout_oe_o = s.dout_oe;
	assign eoc_n_o = s.eoc_n;
	assign conv_start_o = s.conv_start;
	assign conv_chan_o = s.conv_reg[CONV_CHAN_LSB +: 4];
	assign conv_temp_o = s.conv_reg[CONV_TEMP_BIT];
	assign int_start_o = s.int_start;
	assign abort_o = s.abort;
	assign clk_mode_o = s.setup_reg[SETUP_CLK_LSB +: 2];
	assign ref_mode_o = s.setup_reg[SETUP_REF_LSB +: 2];
	assign scan_mode_o = s.scan_mode;
	assign avg_on_o = s.avg_on;
	assign avg_count_o = s.avg_reg[AVG_N_LSB +: 2];
	assign res_ready_o = fifo_in_ready;
endmodule

// ===== test/adc_serial_port_monitor.sv
// Pin-level assertions for the serial conversion port.
`timescale 1ns/1ps
module adc_serial_port_monitor
	import adc_xclk_pkg::*;
(
	// Clock, reset and pins
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic cs_n_i,
	input wire logic convert_start_n_i,
	input wire logic scan_done_i,
	input wire logic res_valid_i,
	// Design outputs
	input wire logic dout_o,
	input wire logic dout_oe_o,
	input wire logic eoc_n_o,
	input wire logic conv_start_o,
	input wire logic int_start_o,
	input wire logic [1:0] clk_mode_o,
	input wire logic [1:0] scan_mode_o,
	input wire logic avg_on_o,
	input wire logic res_ready_o
);
	// One clock domain throughout
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Serial-clocked starts are single pulses, issued while the port is selected
	a_start_pulse: assert property (conv_start_o |-> dout_oe_o ##1 !conv_start_o)
		else $error("conversion start malformed");
	a_ext_quiet: assert property ((clk_mode_o == CLK_MODE_EXT)[*3] |->
		scan_mode_o == 2'h0 && !avg_on_o)
		else $error("scan or averaging active in external clock mode");
	a_ext_only: assert property (conv_start_o |-> clk_mode_o == CLK_MODE_EXT)
		else $error("serial-clocked start outside mode 11");
	a_int_other: assert property (int_start_o |-> clk_mode_o != CLK_MODE_EXT)
		else $error("internal start in mode 11");
	// Sync chain is three flops plus the output register
	a_idle_dout: assert property (cs_n_i[*5] |-> !dout_oe_o && !dout_o)
		else $error("data out driven while deselected");
	a_eoc_hold: assert property ((!eoc_n_o && cs_n_i && convert_start_n_i)[*5] |=> !eoc_n_o)
		else $error("end flag released without a falling pin");
	a_done_eoc: assert property (scan_done_i |-> ##[1:4] !eoc_n_o)
		else $error("end flag missing after scan");
	a_full_cause: assert property ($fell(res_ready_o) |->
		$past(res_valid_i) || $past(res_valid_i, 2))
		else $error("buffer full without a push");
endmodule

bind adc_serial_port adc_serial_port_monitor mon (.mclk_i, .rst_n_i, .cs_n_i,
	.convert_start_n_i, .scan_done_i, .res_valid_i, .dout_o, .dout_oe_o, .eoc_n_o,
	.conv_start_o, .int_start_o, .clk_mode_o, .scan_mode_o, .avg_on_o, .res_ready_o);

// ===== test/spi_host_model.sv
// Serial host model: chip select, serial clock and data in, samples data out.
`timescale 1ns/1ps
module spi_host_model (
	// Serial pins towards the converter
	output logic cs_n_o,
	output logic sclk_o,
	output logic din_o,
	input wire logic dout_i
);
	localparam int HALF_NS = 24;

	// Deselected, clock parked low between frames
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		din_o = 1'b1;
	end

	// One frame of n clocks, MSB first; data changes on falls, sampled on rises
	task automatic xfer(input int n, input logic [255:0] tx, output logic [255:0] rx);
		rx = '0;
		cs_n_o = 1'b0;
		#(2 * HALF_NS);
		for (int i = n - 1; i >= 0; i--) begin
			din_o = tx[i];
			#(HALF_NS);
			sclk_o = 1'b1;
			rx = {rx[254:0], dout_i};
			#(HALF_NS);
			sclk_o = 1'b0;
		end
		#(HALF_NS);
		cs_n_o = 1'b1;
		din_o = ~din_o; // Released line shows no stale level
		#(4 * HALF_NS);
	endtask
endmodule

// ===== test/tb_adc_serial_port.sv
// Self-checking bench for the serial conversion port.
`timescale 1ns/1ps
module tb_adc_serial_port
	import adc_xclk_pkg::*;
;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic convert_start_n_i = 1'b1;
	logic conv_done_i = 1'b0;
	logic [11:0] conv_data_i = 12'h000;
	logic scan_done_i = 1'b0;
	logic res_valid_i = 1'b0;
	logic [15:0] res_data_i = 16'h0000;
	logic cs_n_i, sclk_i, din_i, dout_o, dout_oe_o, eoc_n_o, conv_start_o, conv_temp_o;
	logic int_start_o, abort_o, avg_on_o, res_ready_o;
	logic [3:0] conv_chan_o;
	logic [1:0] clk_mode_o, ref_mode_o, scan_mode_o, avg_count_o;
	int num_errors = 0;
	int total_checks = 0;
	int n_conv = 0;
	int n_int = 0;
	int n_abort = 0;
	int dly = 0;
	int i, k, acc, nc;
	logic [3:0] c;
	logic [11:0] d;
	logic [15:0] w;
	logic [255:0] rx, tx;
	logic [11:0] core_q[$];
	logic [15:0] fq[$];
	logic [15:0] exp_q[$];

	adc_serial_port #(.CS_HIGH_LIMIT(200)) dut (.mclk_i, .rst_n_i, .cs_n_i, .sclk_i, .din_i,
		.dout_o, .dout_oe_o, .convert_start_n_i, .eoc_n_o, .conv_start_o, .conv_chan_o,
		.conv_temp_o, .conv_done_i, .conv_data_i, .int_start_o, .abort_o, .scan_done_i,
		.clk_mode_o, .ref_mode_o, .scan_mode_o, .avg_on_o, .avg_count_o, .res_valid_i,
		.res_data_i, .res_ready_o);
	spi_host_model host (.cs_n_o(cs_n_i), .sclk_o(sclk_i), .din_o(din_i), .dout_i(dout_o));

	// 200 MHz system clock
	initial begin
		forever #2.5 mclk_i = ~mclk_i;
	end

	// Analog core stand-in answers each start after a fixed delay; pulse counters
	always @(posedge mclk_i) begin
		conv_done_i <= 1'b0;
		if (conv_start_o === 1'b1) begin
			dly <= 8;
			n_conv <= n_conv + 1;
		end else if (dly > 0) begin
			dly <= dly - 1;
			if (dly == 1) begin
				conv_done_i <= 1'b1;
				conv_data_i <= core_q.pop_front();
			end
		end
		if (int_start_o === 1'b1) n_int <= n_int + 1;
		if (abort_o === 1'b1) n_abort <= n_abort + 1;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Held low long enough to pass the synchroniser
	task automatic cstart();
		@(posedge mclk_i);
		convert_start_n_i <= 1'b0;
		cyc(8);
		convert_start_n_i <= 1'b1;
		cyc(10);
	endtask

	task automatic summarize();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog: the sequence needs under a fifth of this
	initial begin
		#200000;
		num_errors++;
		summarize();
	end

	initial begin
		void'($urandom(88366));
		cyc(6);
		rst_n_i <= 1'b1;
		cyc(4);
		chk(16'(clk_mode_o), 16'h2);
		chk(16'(eoc_n_o), 16'h1);
		// Fill the result buffer until it refuses
		w = {4'h0, 12'($urandom)};
		res_data_i <= w;
		res_valid_i <= 1'b1;
		acc = 0;
		repeat (12) begin
			@(negedge mclk_i);
			if (res_ready_o === 1'b1) begin
				fq.push_back(w);
				acc++;
				w = {4'h0, 12'($urandom)};
			end
			@(posedge mclk_i);
			res_data_i <= w;
		end
		res_valid_i <= 1'b0;
		chk(16'(acc), 16'(FIFO_DEPTH));
		// Cut-short reads, then drain the rest whole
		host.xfer(5, '0, rx);
		chk(rx[15:0], fq[0] >> 11);
		host.xfer(8, '0, rx);
		chk(rx[15:0], fq.pop_front() & 16'h00FF);
		host.xfer(12, '0, rx);
		chk(rx[15:0], fq.pop_front() >> 4);
		while (fq.size() > 0) begin
			host.xfer(16, '0, rx);
			chk(rx[15:0], fq.pop_front());
		end
		cyc(4);
		chk(16'(res_ready_o), 16'h1);
		// Mode 00: pin start, end flag held, abort by early select
		host.xfer(8, 256'h40, rx);
		cstart();
		chk(16'(n_int), 16'h1);
		@(posedge mclk_i);
		scan_done_i <= 1'b1;
		@(posedge mclk_i);
		scan_done_i <= 1'b0;
		cyc(40);
		chk(16'(eoc_n_o), 16'h0);
		cstart();
		chk(16'(eoc_n_o), 16'h1);
		host.xfer(8, '0, rx);
		chk(16'(n_abort), 16'h1);
		// Mode 11, reference 01 needs no wake-up wait; averaging request ignored
		host.xfer(8, 256'h74, rx);
		host.xfer(8, 256'h3C, rx);
		cyc(4);
		chk(16'(clk_mode_o), 16'(CLK_MODE_EXT));
		chk(16'(avg_on_o), 16'h0);
		chk(16'(avg_count_o), 16'h3);
		nc = 0;
		for (k = 1; k <= 3; k++) begin
			tx = '0;
			for (i = 0; i < k; i++) begin
				c = 4'($urandom);
				d = 12'($urandom);
				core_q.push_back(d);
				exp_q.push_back({4'h0, d[9:0], 2'b00});
				tx = {tx[239:0], 1'b1, c, 2'($urandom), 1'b0, 8'h00};
			end
			tx = {tx[247:0], 8'h00};
			host.xfer(16 * k + 8, tx, rx);
			nc += k;
			for (i = k - 1; i >= 0; i--) chk(16'(rx >> (16 * i)), exp_q.pop_front());
			chk(16'(n_conv), 16'(nc));
			chk(16'(conv_chan_o), 16'(c));
			chk(16'(scan_mode_o), 16'h0);
			chk(16'(eoc_n_o), 16'h0);
		end
		// Temperature: 24 zero bytes after the request, result in the last two
		d = 12'($urandom);
		core_q.push_back(d);
		host.xfer(200, 256'h81 << 192, rx);
		chk(rx[15:0], {4'h0, d});
		chk(16'(conv_temp_o), 16'h1);
		// Conversion byte, short chip-select gap, then the 16 clocks
		d = 12'($urandom);
		core_q.push_back(d);
		host.xfer(8, 256'h88, rx);
		host.xfer(16, '0, rx);
		chk(rx[15:0], {4'h0, d[9:0], 2'b00});
		// A gap longer than the limit abandons the conversion
		core_q.push_back(12'($urandom));
		host.xfer(8, 256'h88, rx);
		cyc(300);
		chk(16'(n_abort), 16'h2);
		// Cut-short setup write: top five bits only
		host.xfer(5, 256'h09, rx);
		cyc(4);
		chk(16'(clk_mode_o), 16'h0);
		chk(16'(ref_mode_o), 16'h3);
		// Reset register restores mode 10, where a conversion byte starts the sequencer
		host.xfer(8, 256'h10, rx);
		cyc(4);
		chk(16'(clk_mode_o), 16'h2);
		host.xfer(8, 256'h80, rx);
		cyc(4);
		chk(16'(n_int), 16'h3);
		chk(16'(n_conv), 16'(nc + 3));
		summarize();
	end
endmodule
